/* shared/ubwd_pkg.sv */
// constants, carriers and behaviour notes for the upstream window decode block
package ubwd_pkg;

    // ************************************************************
    // register map and field layout
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_WIN_ONE = 8'h58;
    localparam logic [7:0] OFS_WIN_TWO = 8'h5C;
    localparam int FLD_SPACE = 0;
    localparam int FLD_TYPE_LO = 1;
    localparam int FLD_PREFETCH = 3;
    localparam int WIN_ONE_BASE_LO = 6;
    localparam int WIN_TWO_BASE_LO = 14;
    localparam logic [31:0] RST_WIN_ONE = 32'h0000_0000;
    localparam logic [31:0] RST_WIN_TWO = 32'h0000_0000;
    localparam logic [1:0] TYPE_32BIT = 2'h0;

    // ************************************************************
    // setup word and page layout
    // ************************************************************
    localparam int SETUP_ENABLE = 31;
    localparam int SETUP_IO = 0;
    localparam int MEM_MIN_SHIFT = 12;
    localparam int IO_MAX_SHIFT = 8;
    localparam int PAGE_COUNT = 64;
    localparam int PAGE_IDX_W = 6;
    localparam int PAGE_MIN_SHIFT = 8;
    localparam int PAGE_CODE_W = 5;
    localparam int PAGE_CODE_MAX = 17;
    localparam int LUT_ENABLE = 0;

    // ************************************************************
    // bus answers
    // ************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic valid;
        logic is_io;
        logic [31:0] addr;
    } ubwd_req_t;

    typedef struct packed {
        logic valid;
        logic hit_one;
        logic hit_two;
        logic [PAGE_IDX_W-1:0] page;
        logic [31:0] addr;
    } ubwd_res_t;

endpackage

/* hdl/ubwd_window_decode.sv */
// combinational hit test and address translation for both windows
module ubwd_window_decode
(
    input wire logic [31:0] setup_one,
    input wire logic [31:0] base_one,
    input wire logic [31:0] xlat_base_one,
    input wire logic [31:0] base_two,
    input wire logic [ubwd_pkg::PAGE_CODE_W-1:0] page_code,
    input wire logic [ubwd_pkg::PAGE_COUNT-1:0][31:0] lut_entry,
    input wire ubwd_pkg::ubwd_req_t req,
    output logic [31:0] mask_one,
    output logic [31:0] mask_two,
    output ubwd_pkg::ubwd_res_t res
);

    logic [ubwd_pkg::PAGE_CODE_W-1:0] code;
    logic [31:0] page_mask;
    logic [ubwd_pkg::PAGE_IDX_W-1:0] page;
    logic [31:0] entry;
    logic one_io;

    // ************************************************************
    // writable masks
    // ************************************************************
    // window one mask follows setup, clamped to the size range
    always_comb
    begin
        one_io = setup_one[ubwd_pkg::SETUP_IO];
        mask_one = setup_one;
        for (int i = 0; i < 32; i++)
        begin
            if (i < ubwd_pkg::WIN_ONE_BASE_LO)
                mask_one[i] = 1'b0;
            else if (!one_io && i < ubwd_pkg::MEM_MIN_SHIFT)
                mask_one[i] = 1'b0;
            else if (one_io && i >= ubwd_pkg::IO_MAX_SHIFT)
                mask_one[i] = 1'b1;
        end
    end

    // window two mask: bits above the window size stay writable
    always_comb
    begin
        code = (page_code > ubwd_pkg::PAGE_CODE_W'(ubwd_pkg::PAGE_CODE_MAX))
            ? ubwd_pkg::PAGE_CODE_W'(ubwd_pkg::PAGE_CODE_MAX) : page_code;
        page_mask = (32'h0000_0001 << (ubwd_pkg::PAGE_MIN_SHIFT + int'(code))) - 32'h0000_0001;
        mask_two = ~((32'h0000_0001 << (ubwd_pkg::WIN_TWO_BASE_LO + int'(code)))
            - 32'h0000_0001);
    end

    // ************************************************************
    // hit and translation
    // ************************************************************
    always_comb
    begin
        page = ubwd_pkg::PAGE_IDX_W'(req.addr >> (ubwd_pkg::PAGE_MIN_SHIFT + int'(code)));
        entry = lut_entry[page];
        res = '0;
        res.valid = req.valid;
        res.page = page;
        res.hit_one = req.valid && setup_one[ubwd_pkg::SETUP_ENABLE]
            && (req.is_io == one_io)
            && ((req.addr & mask_one) == (base_one & mask_one));
        res.hit_two = req.valid && !req.is_io
            && ((req.addr & mask_two) == (base_two & mask_two))
            && entry[ubwd_pkg::LUT_ENABLE];
        if (res.hit_one)
            res.addr = (xlat_base_one & mask_one) | (req.addr & ~mask_one);
        else if (res.hit_two)
            res.addr = (entry & ~page_mask) | (req.addr & page_mask);
        else
            res.addr = req.addr;
    end

endmodule

/* hdl/ubwd_top.sv */
// upstream window base registers with an AXI4-Lite slave and decode stage
module ubwd_top
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [ubwd_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ubwd_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] setup_one,
    input wire logic [31:0] xlat_base_one,
    input wire logic [ubwd_pkg::PAGE_CODE_W-1:0] page_code,
    input wire logic [ubwd_pkg::PAGE_COUNT-1:0][31:0] lut_entry,
    input wire ubwd_pkg::ubwd_req_t req,
    output ubwd_pkg::ubwd_res_t res
);

    // ************************************************************
    // state
    // ************************************************************
    logic [31:0] base_one;
    logic [31:0] base_two;
    logic [1:0] type_one;
    logic prefetch_one;
    logic aw_held;
    logic [ubwd_pkg::ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held;
    logic [ubwd_pkg::ADDR_W-1:0] next_aw_addr;
    logic next_w_held;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic [31:0] next_base_one;
    logic [31:0] next_base_two;
    logic [1:0] next_type_one;
    logic next_prefetch_one;
    logic next_arready;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    ubwd_pkg::ubwd_res_t next_res;
    ubwd_pkg::ubwd_res_t dec_res;
    logic [31:0] mask_one;
    logic [31:0] mask_two;
    logic [31:0] merged;
    logic [31:0] view_one;
    logic [31:0] view_two;
    logic do_write;

    // ************************************************************
    // decode unit
    // ************************************************************
    ubwd_window_decode u_decode
    (
        .setup_one(setup_one),
        .base_one(base_one),
        .xlat_base_one(xlat_base_one),
        .base_two(base_two),
        .page_code(page_code),
        .lut_entry(lut_entry),
        .req(req),
        .mask_one(mask_one),
        .mask_two(mask_two),
        .res(dec_res)
    );

    // ************************************************************
    // register views
    // ************************************************************
    // read images: base bits masked, reserved and space bits zero
    always_comb
    begin
        view_one = base_one & mask_one;
        view_one[ubwd_pkg::FLD_SPACE] = 1'b0;
        view_one[ubwd_pkg::FLD_TYPE_LO +: 2] = type_one;
        view_one[ubwd_pkg::FLD_PREFETCH] = prefetch_one;
        view_one[5:4] = 2'h0;
        view_two = base_two & mask_two;
        view_two[ubwd_pkg::FLD_SPACE] = 1'b0;
        view_two[ubwd_pkg::FLD_TYPE_LO +: 2] = ubwd_pkg::TYPE_32BIT;
        view_two[ubwd_pkg::FLD_PREFETCH] = 1'b0;
        view_two[ubwd_pkg::WIN_TWO_BASE_LO-1:4] = '0;
    end

    // ************************************************************
    // write channel
    // ************************************************************
    // hold address and data until both are in, then answer
    always_comb
    begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_base_one = base_one;
        next_base_two = base_two;
        merged = 32'h0000_0000;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
            next_bvalid = 1'b0;
        do_write = next_aw_held && next_w_held && !next_bvalid;
        if (do_write)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = ubwd_pkg::RESP_OKAY;
            if (next_aw_addr == ubwd_pkg::OFS_WIN_ONE)
            begin
                for (int b = 0; b < 4; b++)
                    merged[8*b +: 8] = next_w_strb[b] ? next_w_data[8*b +: 8]
                        : base_one[8*b +: 8];
                next_base_one = (base_one & ~mask_one) | (merged & mask_one);
            end
            else if (next_aw_addr == ubwd_pkg::OFS_WIN_TWO)
            begin
                for (int b = 0; b < 4; b++)
                    merged[8*b +: 8] = next_w_strb[b] ? next_w_data[8*b +: 8]
                        : base_two[8*b +: 8];
                next_base_two = (base_two & ~mask_two) | (merged & mask_two);
            end
            else
                next_bresp = ubwd_pkg::RESP_SLVERR;
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
    end

    // ************************************************************
    // read-only fields of window one
    // ************************************************************
    // address type and prefetch track the setup word
    always_comb
    begin
        next_type_one = setup_one[ubwd_pkg::FLD_TYPE_LO +: 2];
        next_prefetch_one = setup_one[ubwd_pkg::FLD_PREFETCH];
    end

    // ************************************************************
    // read channel
    // ************************************************************
    always_comb
    begin
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready)
            next_rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp = ubwd_pkg::RESP_OKAY;
            case (s_axi_araddr)
                ubwd_pkg::OFS_WIN_ONE: next_rdata = view_one;
                ubwd_pkg::OFS_WIN_TWO: next_rdata = view_two;
                default:
                begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = ubwd_pkg::RESP_SLVERR;
                end
            endcase
        end
        next_arready = !next_rvalid;
    end

    // ************************************************************
    // decode result stage
    // ************************************************************
    // one registered result per request
    always_comb
    begin
        next_res = dec_res;
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ubwd_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ubwd_pkg::RESP_OKAY;
            base_one <= ubwd_pkg::RST_WIN_ONE;
            base_two <= ubwd_pkg::RST_WIN_TWO;
            type_one <= ubwd_pkg::TYPE_32BIT;
            prefetch_one <= 1'b0;
            res <= '0;
        end
        else if (ce)
        begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            base_one <= next_base_one;
            base_two <= next_base_two;
            type_one <= next_type_one;
            prefetch_one <= next_prefetch_one;
            res <= next_res;
        end
    end

endmodule

/* tb/ubwd_lut_model.sv */
// far-side lookup table source, one entry per page of window two
module ubwd_lut_model
(
    input wire logic [ubwd_pkg::PAGE_COUNT-1:0] page_en,
    output logic [ubwd_pkg::PAGE_COUNT-1:0][31:0] lut_entry
);
    timeunit 1ns;
    timeprecision 1ps;
    // target holds the page number under a fixed upper pattern, bit 0 enables
    always_comb
    begin
        for (int i = 0; i < ubwd_pkg::PAGE_COUNT; i++)
        begin
            lut_entry[i] = {16'h7700, 2'h0, 6'(i), 7'h00, page_en[i]};
        end
    end
endmodule

/* tb/ubwd_assertions.sv */
// concurrent checks on the bus and decode ports of the window block
module ubwd_checker
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] setup_one,
    input wire ubwd_pkg::ubwd_req_t req,
    input wire ubwd_pkg::ubwd_res_t res
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both halves of a write taken at one edge
    sequence s_write_done;
        ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // decode request accepted
    sequence s_req_taken;
        ce && req.valid;
    endsequence
    a_write_answer: assert property (s_write_done |=> s_axi_bvalid)
        else $error("write not answered");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_read_answer: assert property (ce && s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("read not answered");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_res_pulse: assert property (s_req_taken |=> res.valid)
        else $error("decode result missing");
    a_res_idle: assert property (ce && !req.valid |=> !res.valid)
        else $error("decode result without request");
    a_off_no_hit: assert property ((s_req_taken and (!setup_one[31])) |=> !res.hit_one)
        else $error("disabled window one hit");
    a_io_not_two: assert property ((s_req_taken and (req.is_io)) |=> !res.hit_two)
        else $error("io request hit window two");
    a_miss_passes: assert property (s_req_taken ##1 (!res.hit_one && !res.hit_two) |->
        res.addr == $past(req.addr)) else $error("missed address altered");
    a_one_low_bits: assert property (s_req_taken ##1 res.hit_one |->
        res.addr[5:0] == $past(req.addr[5:0])) else $error("window one offset altered");
endmodule
bind ubwd_top ubwd_checker chk_u (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .setup_one(setup_one), .req(req), .res(res));

/* tb/testbench.sv */
// self-checking bench for the upstream window decode block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [31:0] setup_one = 32'h0000_0000;
    logic [31:0] xlat_base_one = 32'hA000_0000;
    logic [4:0] page_code = 5'h00;
    logic [63:0] page_en = 64'h0;
    logic [63:0][31:0] lut_entry;
    ubwd_pkg::ubwd_req_t req = '0;
    ubwd_pkg::ubwd_res_t res;
    logic [31:0] q;
    logic [1:0] r;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    ubwd_top dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .setup_one(setup_one), .xlat_base_one(xlat_base_one), .page_code(page_code),
        .lut_entry(lut_entry), .req(req), .res(res));
    ubwd_lut_model lut_u (.page_en(page_en), .lut_entry(lut_entry));
    // free-running clock
    initial
    begin
        forever #10 aclk = ~aclk;
    end
    // hang guard
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus_write(logic [7:0] a, logic [31:0] d, output logic [1:0] rsp);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        rsp = bresp;
        bready <= 1'b0;
    endtask
    task automatic bus_read(logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask
    // write, then read back and compare both answers
    task automatic wr_rd(string what, logic [7:0] a, logic [31:0] d, logic [1:0] er,
        logic [31:0] ed);
        logic [1:0] rs;
        logic [31:0] rv;
        bus_write(a, d, rs);
        check({what, " bresp"}, 32'(rs), 32'(er));
        bus_read(a, rv, rs);
        check({what, " rresp"}, 32'(rs), 32'(er));
        check(what, rv, ed);
    endtask
    // one decode request, result checked the cycle after
    task automatic probe(string what, logic io, logic [31:0] a, logic [1:0] eh,
        logic [31:0] ea);
        @(posedge aclk);
        req <= '{valid: 1'b1, is_io: io, addr: a};
        @(posedge aclk);
        req.valid <= 1'b0;
        #1;
        check({what, " hits"}, 32'({res.valid, res.hit_one, res.hit_two}), 32'({1'b1, eh}));
        check({what, " addr"}, res.addr, ea);
    endtask
    // main sequence
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        bus_read(ubwd_pkg::OFS_WIN_ONE, q, r);
        check("one reset", q, 32'h0000_0000);
        bus_read(ubwd_pkg::OFS_WIN_TWO, q, r);
        check("two reset", q, 32'h0000_0000);
        wr_rd("unmapped", 8'h60, 32'hFFFF_FFFF, ubwd_pkg::RESP_SLVERR, 32'h0);
        $display("test reset and map done");
        setup_one <= 32'hFFFF_FFCA;
        wr_rd("one mem", ubwd_pkg::OFS_WIN_ONE, 32'h1234_5FFF, 2'h0, 32'h1234_500A);
        probe("one hit", 1'b0, 32'h1234_5ABC, 2'b10, 32'hA000_0ABC);
        probe("one io", 1'b1, 32'h1234_5ABC, 2'b00, 32'h1234_5ABC);
        probe("one out", 1'b0, 32'h1234_6000, 2'b00, 32'h1234_6000);
        setup_one <= 32'h7FFF_FFCA;
        probe("one off", 1'b0, 32'h1234_5ABC, 2'b00, 32'h1234_5ABC);
        setup_one <= 32'h8000_0001;
        wr_rd("one io", ubwd_pkg::OFS_WIN_ONE, 32'hFFFF_FFFF, 2'h0, 32'hFFFF_FF00);
        probe("io hit", 1'b1, 32'hFFFF_FF42, 2'b10, 32'hA000_0042);
        $display("test window one done");
        setup_one <= 32'h0000_0000;
        wr_rd("two all", ubwd_pkg::OFS_WIN_TWO, 32'hFFFF_FFFF, 2'h0, 32'hFFFF_C000);
        page_code <= 5'h02;
        bus_read(ubwd_pkg::OFS_WIN_TWO, q, r);
        check("two big page", q, 32'hFFFF_0000);
        page_code <= 5'h00;
        wr_rd("two base", ubwd_pkg::OFS_WIN_TWO, 32'h4000_0000, 2'h0, 32'h4000_0000);
        page_en <= 64'h8000_0000_0000_0008;
        probe("page 3", 1'b0, 32'h4000_0312, 2'b01, 32'h7700_0312);
        check("page 3 index", 32'(res.page), 32'h3);
        probe("page 63", 1'b0, 32'h4000_3F05, 2'b01, 32'h7700_3F05);
        check("page 63 index", 32'(res.page), 32'h3F);
        probe("page off", 1'b0, 32'h4000_0412, 2'b00, 32'h4000_0412);
        probe("two io", 1'b1, 32'h4000_0312, 2'b00, 32'h4000_0312);
        probe("two out", 1'b0, 32'h4000_4000, 2'b00, 32'h4000_4000);
        $display("test window two done");
        // clock enable low freezes the decode stage, request held across the stall
        @(posedge aclk);
        ce <= 1'b0;
        req <= '{valid: 1'b1, is_io: 1'b0, addr: 32'h4000_0312};
        repeat (3) @(posedge aclk);
        check("frozen res", 32'(res.valid), 32'h0);
        ce <= 1'b1;
        @(posedge aclk);
        req.valid <= 1'b0;
        #1;
        check("thaw hit", 32'({res.valid, res.hit_two}), 32'h3);
        check("thaw addr", res.addr, 32'h7700_0312);
        $display("test clock enable done");
        // second reset in mid-run clears both bases
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        bus_read(ubwd_pkg::OFS_WIN_TWO, q, r);
        check("two rereset", q, 32'h0000_0000);
        bus_read(ubwd_pkg::OFS_WIN_ONE, q, r);
        check("one rereset", q, 32'h0000_0000);
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule
